// file: core/spc_core.sv
// Purpose: Serial peripheral controller, initiator or target, with FIFOs.
// Assumes: Half period of the serial clock is at least four core cycles.
// Notes:   Link inputs pass two flip-flops before use.

// ----------------------------------------------------------------------
// Word FIFO
// ----------------------------------------------------------------------
module spc_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  output logic              rd_valid,
  output logic      [W-1:0] rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  assign wr_ready = cnt_r != DEPTH[AW:0];
  assign rd_valid = cnt_r != '0;
  assign rd_data  = mem[rp_r];
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_r] <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : spc_fifo

// ----------------------------------------------------------------------
// Controller
// ----------------------------------------------------------------------
module spc_core
  import spc_pkg::*;
#(
  parameter int   FIFO_DEPTH = 8,
  parameter int   NUM_CS     = 2,
  parameter logic RESTRICTED = 1'b0
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic [SPC_DW-1:0]         tx_data,
  input  wire logic                      tx_valid,
  output logic                           tx_ready,
  output logic      [SPC_DW-1:0]         rx_data,
  output logic                           rx_valid,
  input  wire logic                      rx_ready,
  input  wire logic                      initiator_en,
  input  wire logic                      cpol,
  input  wire logic                      cpha,
  input  wire logic [SPC_LW-1:0]         bit_len,
  input  wire logic                      packed_en,
  input  wire logic                      cs_auto,
  input  wire logic                      cs_sw_assert,
  input  wire logic [$clog2(NUM_CS)-1:0] cs_sel,
  input  wire logic [7:0]                clk_div,
  input  wire logic                      run_en,
  input  wire logic                      dual_en,
  input  wire logic                      dir_rx,
  output logic                           busy,
  input  wire logic                      sck_i,
  output logic                           sck_o,
  output logic                           sck_oe,
  input  wire logic                      cs_n_i,
  output logic      [NUM_CS-1:0]         cs_n_o,
  output logic                           cs_n_oe,
  input  wire logic                      mosi_i,
  output logic                           mosi_o,
  output logic                           mosi_oe,
  input  wire logic                      miso_i,
  output logic                           miso_o,
  output logic                           miso_oe
);
  // --------------------------------------------------------------------
  // Effective configuration
  // --------------------------------------------------------------------
  logic             init_m, pol, pha, dual, tx_use, rx_use, pk_ok;
  logic [4:0]       plen;
  logic [5:0]       pbits, wbits, step;
  logic [7:0]       half;

  assign init_m = RESTRICTED | initiator_en;
  assign pol    = RESTRICTED ? 1'b0 : cpol;
  assign pha    = RESTRICTED ? 1'b0 : (init_m ? cpha : 1'b1);
  assign dual   = RESTRICTED & dual_en;
  assign tx_use = ~RESTRICTED | ~dir_rx;
  assign rx_use = ~RESTRICTED | dir_rx;
  assign plen   = (bit_len < SPC_LEN_MIN) ? SPC_LEN_MIN : bit_len;
  assign pbits  = {1'b0, plen} + 6'h01;
  assign pk_ok  = packed_en & (plen == SPC_PK_4 | plen == SPC_PK_8 |
                               plen == SPC_PK_16 | plen == SPC_PK_32);
  assign wbits  = pk_ok ? SPC_WORD_BITS : pbits;
  assign step   = dual ? 6'h02 : 6'h01;
  assign half   = (clk_div < SPC_DIV_MIN) ? SPC_DIV_MIN : clk_div;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] s1_r, s2_r;
  logic       sck_p_r, cs_p_r;
  logic       sck_s, cs_s, mosi_s, miso_s;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r    <= 4'hf;
      s2_r    <= 4'hf;
      sck_p_r <= 1'b1;
      cs_p_r  <= 1'b1;
    end else begin
      s1_r    <= {sck_i, cs_n_i, mosi_i, miso_i};
      s2_r    <= s1_r;
      sck_p_r <= s2_r[3];
      cs_p_r  <= s2_r[2];
    end
  end

  assign sck_s  = s2_r[3];
  assign cs_s   = s2_r[2];
  assign mosi_s = s2_r[1];
  assign miso_s = s2_r[0];

  // --------------------------------------------------------------------
  // FIFOs
  // --------------------------------------------------------------------
  logic              txf_valid, txf_pop, rxf_ready, rxf_push;
  logic [SPC_DW-1:0] txf_data, rx_next;

  spc_fifo #(.W(SPC_DW), .DEPTH(FIFO_DEPTH)) u_txf (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_valid (tx_valid),
    .wr_data  (tx_data),
    .wr_ready (tx_ready),
    .rd_valid (txf_valid),
    .rd_data  (txf_data),
    .rd_ready (txf_pop)
  );

  spc_fifo #(.W(SPC_DW), .DEPTH(FIFO_DEPTH)) u_rxf (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .wr_valid (rxf_push),
    .wr_data  (rx_next),
    .wr_ready (rxf_ready),
    .rd_valid (rx_valid),
    .rd_data  (rx_data),
    .rd_ready (rx_ready)
  );

  // --------------------------------------------------------------------
  // Edge events
  // --------------------------------------------------------------------
  spc_state_t        state_r;
  logic [7:0]        div_r;
  logic              edge_r, sck_r, pend_r, wdone_r;
  logic [5:0]        wb_r, pk_r, wb_nxt, pk_nxt;
  logic [SPC_DW-1:0] tx_sh_r, rx_sh_r, ld_val;
  logic              tick, i_lead, i_trail, t_act, t_lead, t_trail, t_csf;
  logic              lead, trail, samp_ev, shift_ev, pkt_done, word_done;
  logic              go, i_close, load;

  assign tick     = div_r == 8'h00;
  assign i_lead   = init_m & state_r == SPC_RUN & tick & ~edge_r;
  assign i_trail  = init_m & state_r == SPC_RUN & tick & edge_r;
  assign t_act    = ~init_m & ~cs_s;
  assign t_lead   = t_act & (sck_s != sck_p_r) & (sck_s != pol);
  assign t_trail  = t_act & (sck_s != sck_p_r) & (sck_s == pol);
  assign t_csf    = ~init_m & cs_p_r & ~cs_s;
  assign lead     = i_lead | t_lead;
  assign trail    = i_trail | t_trail;
  assign samp_ev  = pha ? trail : lead;
  assign shift_ev = pha ? (lead & wb_r != 6'h00) : trail;
  assign wb_nxt   = wb_r + step;
  assign pk_nxt   = pk_r + step;
  assign pkt_done  = samp_ev & pk_nxt >= pbits;
  assign word_done = samp_ev & wb_nxt >= wbits;
  assign i_close  = i_trail & (pend_r | pkt_done);
  assign go       = init_m & run_en & state_r == SPC_IDLE &
                    (~tx_use | txf_valid) & (~rx_use | rxf_ready);
  assign load     = go | t_csf | (~init_m & word_done & ~cs_s);
  assign txf_pop  = load & tx_use & txf_valid;
  assign ld_val   = (tx_use & txf_valid) ? txf_data : '0;
  assign rx_next  = dual ? {rx_sh_r[SPC_DW-3:0], miso_s, mosi_s} :
                           {rx_sh_r[SPC_DW-2:0], init_m ? miso_s : mosi_s};
  assign rxf_push = word_done & rx_use & (init_m ? 1'b1 : rxf_ready);

  // --------------------------------------------------------------------
  // Initiator sequencer
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst | ~init_m) begin
      state_r <= SPC_IDLE;
    end else begin
      unique case (state_r)
        SPC_IDLE: begin
          if (go) begin
            state_r <= SPC_SETUP;
          end
        end
        SPC_SETUP: begin
          if (tick) begin
            state_r <= SPC_RUN;
          end
        end
        SPC_RUN: begin
          if (i_close) begin
            state_r <= SPC_GAP;
          end
        end
        SPC_GAP: begin
          if (tick) begin
            state_r <= wdone_r ? SPC_IDLE : SPC_SETUP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_r  <= 8'h00;
      edge_r <= 1'b0;
      sck_r  <= 1'b0;
    end else begin
      if (state_r == SPC_IDLE | tick) begin
        div_r <= half - 8'h01;
      end else begin
        div_r <= div_r - 8'h01;
      end
      if (state_r != SPC_RUN) begin
        edge_r <= 1'b0;
        sck_r  <= pol;
      end else if (tick) begin
        edge_r <= ~edge_r;
        sck_r  <= ~sck_r;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pend_r  <= 1'b0;
      wdone_r <= 1'b0;
    end else begin
      pend_r  <= ~i_close & (pend_r | pkt_done);
      wdone_r <= ~load & (wdone_r | word_done);
    end
  end

  // --------------------------------------------------------------------
  // Shift path
  // --------------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_sh_r <= '0;
      rx_sh_r <= '0;
      wb_r    <= 6'h00;
      pk_r    <= 6'h00;
    end else if (load | (~init_m & cs_s)) begin
      tx_sh_r <= load ? (pk_ok ? ld_val : ld_val << (SPC_WORD_BITS - pbits)) : tx_sh_r;
      rx_sh_r <= '0;
      wb_r    <= 6'h00;
      pk_r    <= 6'h00;
    end else begin
      if (shift_ev) begin
        tx_sh_r <= dual ? {tx_sh_r[SPC_DW-3:0], 2'b00} : {tx_sh_r[SPC_DW-2:0], 1'b0};
      end
      if (samp_ev) begin
        rx_sh_r <= rx_next;
        wb_r    <= word_done ? 6'h00 : wb_nxt;
        pk_r    <= pkt_done ? 6'h00 : pk_nxt;
      end
    end
  end

  // --------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------
  logic cs_act;
  logic [NUM_CS-1:0] cs_n_r;

  assign cs_act = cs_auto ? (state_r == SPC_SETUP | state_r == SPC_RUN) : cs_sw_assert;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cs_n_r <= '1;
    end else begin
      for (int i = 0; i < NUM_CS; i++) begin
        cs_n_r[i] <= ~(init_m & cs_act & cs_sel == i[$clog2(NUM_CS)-1:0]);
      end
    end
  end

  assign cs_n_o  = cs_n_r;
  assign cs_n_oe = init_m;
  assign sck_o   = sck_r;
  assign sck_oe  = init_m;
  assign mosi_o  = dual ? tx_sh_r[SPC_DW-2] : tx_sh_r[SPC_DW-1];
  assign miso_o  = tx_sh_r[SPC_DW-1];
  assign mosi_oe = init_m & tx_use;
  assign miso_oe = t_act | (init_m & dual & tx_use);
  assign busy    = state_r != SPC_IDLE | t_act;

endmodule : spc_core

// file: core/spc_pkg.sv
// Purpose: Shared constants and types of the serial peripheral controller.
// Assumes: One core clock; every link pin is sampled by that clock.
// Notes:   Packet lengths are held as length minus one.
// Behaviour
// - Link uses active-low chip select, serial clock and two data lines.
// - Sender changes data on one clock edge, receiver captures on the other.
// - Modes 0 and 3 sample on rising edge, drive on falling edge.
// - Modes 1 and 2 sample on falling edge, drive on rising edge.
// - Initiator supports all four modes; clock idles at the polarity level.
// - Target supports only modes 1 and 3.
// - Receive and transmit FIFOs work independently.
// - Software sets packet length from 4 to 32 bits.
// - Packed mode only for length settings 3, 7, 15 and 31.
// - Chip select driven by software or automatically at packet boundaries.
// - Receive and transmit proceed together in one transfer.
// - Instances one and three offer two selectable chip-select outputs.
// - Restricted instance is initiator only, mode 0, single data rate.
// - Restricted instance does single-lane and dual-lane, both half-duplex.
package spc_pkg;

  localparam int         SPC_DW        = 32;
  localparam int         SPC_LW        = 5;
  localparam logic [4:0] SPC_LEN_MIN   = 5'h03;
  localparam logic [4:0] SPC_PK_4      = 5'h03;
  localparam logic [4:0] SPC_PK_8      = 5'h07;
  localparam logic [4:0] SPC_PK_16     = 5'h0f;
  localparam logic [4:0] SPC_PK_32     = 5'h1f;
  localparam logic [5:0] SPC_WORD_BITS = 6'h20;
  localparam logic [7:0] SPC_DIV_MIN   = 8'h04;

  typedef enum logic [1:0] {SPC_IDLE, SPC_SETUP, SPC_RUN, SPC_GAP} spc_state_t;

endpackage : spc_pkg

// file: sim/spc_core_properties.sv
// Purpose: Port-level checks of the serial peripheral controller.
// Assumes: One core clock; reset is synchronous and active high.
// Notes:   Serial clock edges are counted per automatic packet.
module spc_core_properties
  import spc_pkg::*;
#(
  parameter int NUM_CS = 2
) (
  input wire logic                      core_clk,
  input wire logic                      sys_rst,
  input wire logic                      rx_valid,
  input wire logic                      initiator_en,
  input wire logic                      cpol,
  input wire logic [SPC_LW-1:0]         bit_len,
  input wire logic                      cs_auto,
  input wire logic                      cs_sw_assert,
  input wire logic [$clog2(NUM_CS)-1:0] cs_sel,
  input wire logic                      busy,
  input wire logic                      sck_o,
  input wire logic                      sck_oe,
  input wire logic [NUM_CS-1:0]         cs_n_o,
  input wire logic                      cs_n_oe,
  input wire logic                      mosi_oe
);
  logic [6:0] edge_cnt_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst || &cs_n_o) edge_cnt_r <= 7'h00;
    else if ($changed(sck_o)) edge_cnt_r <= edge_cnt_r + 7'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_rst_idle; $fell(sys_rst) |-> &cs_n_o && !busy && !rx_valid; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
  property p_cs_one; $countones(~cs_n_o) <= 1; endproperty
  a_cs_one: assert property (p_cs_one) else $error("two selects low");
  property p_sw_on; initiator_en && !cs_auto && cs_sw_assert |-> ##[0:4] !cs_n_o[cs_sel]; endproperty
  a_sw_on: assert property (p_sw_on) else $error("software select not driven");
  sequence s_sw_off; (initiator_en && !cs_auto && !cs_sw_assert) [*4]; endsequence
  property p_sw_off; s_sw_off |-> &cs_n_o; endproperty
  a_sw_off: assert property (p_sw_off) else $error("software select not released");
  property p_sck_rest; initiator_en && cs_auto && &cs_n_o && $changed(sck_o) |-> sck_o == cpol; endproperty
  a_sck_rest: assert property (p_sck_rest) else $error("clock moved while deselected");
  property p_busy; initiator_en && cs_auto && !(&cs_n_o) |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("selected while not busy");
  property p_edges; initiator_en && cs_auto && $rose(&cs_n_o) |-> edge_cnt_r == 7'(2 * (bit_len + 1)); endproperty
  a_edges: assert property (p_edges) else $error("wrong clock edge count in packet");
  property p_init_oe; initiator_en [*3] |-> sck_oe && cs_n_oe && mosi_oe; endproperty
  a_init_oe: assert property (p_init_oe) else $error("initiator not driving link");
  property p_tgt_oe; (!initiator_en) [*3] |-> !sck_oe && !cs_n_oe && !mosi_oe; endproperty
  a_tgt_oe: assert property (p_tgt_oe) else $error("target drives initiator lines");
  c_packet: cover property (initiator_en && cs_auto && $rose(&cs_n_o));
  c_sw: cover property (!cs_auto && !cs_n_o[cs_sel]);
  c_target: cover property (!initiator_en && rx_valid);
endmodule : spc_core_properties

// file: sim/spc_core_tb.sv
// Purpose: Self-checking bench for the serial peripheral controller.
// Assumes: A divider of 4 gives an 80 ns serial clock.
// Notes:   The far side is a behavioural peripheral model.
module spc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0, sys_rst = 1'h1, tx_valid = 1'h0, rx_ready = 1'h0, initiator_en = 1'h1;
  logic        cpol = 1'h0, cpha = 1'h0, packed_en = 1'h0, cs_auto = 1'h1, cs_sw_assert = 1'h0, cs_sel = 1'h0;
  logic        run_en = 1'h0, tb_sck = 1'h1, tb_cs_n = 1'h1, tb_mosi = 1'h0;
  logic        tx_ready, rx_valid, busy, sck_o, sck_oe, cs_n_oe, mosi_o, mosi_oe, miso_o, miso_oe, mdl_miso;
  logic [1:0]  cs_n_o;
  logic [4:0]  bit_len = 5'h07;
  logic [5:0]  nbits = 6'h08;
  logic [7:0]  pkts;
  logic [31:0] tx_data = 32'h0, reply = 32'h0, rx_data, got;
  int          miscompares = 0, check_count = 0;
  wire         sck_w = sck_oe ? sck_o : tb_sck;
  wire         cs_w = cs_n_oe ? cs_n_o[0] : tb_cs_n;
  wire         mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire         miso_w = miso_oe ? miso_o : mdl_miso;
  always #5 core_clk = ~core_clk;
  spc_core u_spc_core (
    .core_clk, .sys_rst, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready, .initiator_en,
    .cpol, .cpha, .bit_len, .packed_en, .cs_auto, .cs_sw_assert, .cs_sel, .clk_div(8'h04), .run_en,
    .dual_en(1'h0), .dir_rx(1'h0), .busy, .sck_i(sck_w), .sck_o, .sck_oe, .cs_n_i(cs_w), .cs_n_o, .cs_n_oe,
    .mosi_i(mosi_w), .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe
  );
  spc_target_model u_spc_target_model (
    .sck(sck_w), .cs_n(cs_n_o[0] | ~cs_n_oe), .mosi(mosi_w), .cpol, .cpha, .reply, .nbits, .miso(mdl_miso),
    .got, .pkts
  );
  task automatic test_done;
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    check_count++;
    if (act !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, act, exp);
    end
  endtask : chk
  task automatic wait_rx;
    for (int n = 0; n < 3000 && rx_valid !== 1'h1; n++) @(negedge core_clk);
    chk({31'h0, rx_valid}, 32'h1);
  endtask : wait_rx
  task automatic pop;
    rx_ready = 1'h1;
    @(negedge core_clk);
    rx_ready = 1'h0;
  endtask : pop
  task automatic push(input logic [31:0] d);
    tx_data = d;
    tx_valid = 1'h1;
    @(negedge core_clk);
    tx_valid = 1'h0;
  endtask : push
  // ----
  // Scenarios.
  // ----
  task automatic xfer(input logic [1:0] md, input logic [4:0] bl, input logic [31:0] tx, input logic [31:0] rp);
    logic [31:0] m;
    m = 32'hffffffff >> (5'h1f - bl);
    {cpol, cpha} = md;
    bit_len = bl;
    nbits = {1'h0, bl} + 6'h01;
    reply = rp;
    push(tx);
    run_en = 1'h1;
    wait_rx;
    run_en = 1'h0;
    chk(rx_data, rp & m);
    chk(got, tx & m);
    pop;
    for (int n = 0; n < 200 && cs_n_o[0] !== 1'h1; n++) @(negedge core_clk);
    repeat (8) @(negedge core_clk);
  endtask : xfer
  task automatic packed_run;
    logic [7:0] p0;
    p0 = pkts;
    packed_en = 1'h1;
    bit_len = 5'h07;
    nbits = 6'h08;
    reply = 32'hc3;
    push(32'h12345678);
    run_en = 1'h1;
    for (int k = 0; k < 4; k++) begin
      for (int n = 0; n < 400 && pkts !== p0 + 8'(k + 1); n++) @(negedge core_clk);
      chk(got, (32'h12345678 >> (24 - 8 * k)) & 32'hff);
    end
    run_en = 1'h0;
    packed_en = 1'h0;
    wait_rx;
    chk(rx_data, 32'hc3c3c3c3);
    pop;
    repeat (8) @(negedge core_clk);
  endtask : packed_run
  task automatic sw_cs;
    cs_auto = 1'h0;
    cs_sel = 1'h1;
    cs_sw_assert = 1'h1;
    repeat (6) @(negedge core_clk);
    chk({30'h0, cs_n_o}, 32'h1);
    cs_sw_assert = 1'h0;
    repeat (6) @(negedge core_clk);
    chk({30'h0, cs_n_o}, 32'h3);
    cs_sel = 1'h0;
    cs_auto = 1'h1;
  endtask : sw_cs
  task automatic tgt_run;
    logic [7:0] q, s;
    s = 8'h5a;
    initiator_en = 1'h0;
    {cpol, cpha} = 2'h3;
    bit_len = 5'h07;
    push(32'h96);
    chk({31'h0, tx_ready}, 32'h1);
    tb_cs_n = 1'h0;
    #80;
    chk({30'h0, miso_oe, busy}, 32'h3);
    for (int b = 7; b >= 0; b--) begin
      tb_sck = 1'h0;
      tb_mosi = s[b];
      #40 tb_sck = 1'h1;
      q[b] = miso_w;
      #40;
    end
    tb_cs_n = 1'h1;
    tb_mosi = ~tb_mosi;
    @(negedge core_clk);
    wait_rx;
    chk({24'h0, q}, 32'h96);
    chk(rx_data, 32'h5a);
    pop;
    initiator_en = 1'h1;
  endtask : tgt_run
  initial begin
    repeat (4) @(negedge core_clk);
    chk({29'h0, busy, cs_n_o}, 32'h3);
    sys_rst = 1'h0;
    @(negedge core_clk);
    for (int i = 0; i < 4; i++) xfer(i[1:0], 5'h07, 32'ha5 + i, 32'h3c + i);
    xfer(2'h1, 5'h03, 32'h9, 32'h6);
    xfer(2'h2, 5'h1f, 32'h8badf00d, 32'hc001d00d);
    packed_run;
    sw_cs;
    tgt_run;
    test_done;
  end
  initial begin
    #300000;
    miscompares++;
    test_done;
  end
endmodule : spc_core_tb
bind spc_core spc_core_properties #(.NUM_CS(NUM_CS)) u_spc_core_properties (
  .core_clk, .sys_rst, .rx_valid, .initiator_en, .cpol, .bit_len, .cs_auto, .cs_sw_assert, .cs_sel, .busy,
  .sck_o, .sck_oe, .cs_n_o, .cs_n_oe, .mosi_oe
);

// file: sim/spc_target_model.sv
// Purpose: Behavioural peripheral on the far side of the serial link.
// Assumes: Select and clock come from the controller under test.
// Notes:   A released data line shows the inverse of its last value.
module spc_target_model (
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic        mosi,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [31:0] reply,
  input  wire logic [5:0]  nbits,
  output logic             miso,
  output logic      [31:0] got,
  output logic      [7:0]  pkts
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cs_q;
  int   idx;
  initial begin
    miso = 1'h0;
    got = 32'h0;
    pkts = 8'h00;
    idx = -1;
    cs_q = 1'h1;
    forever begin
      @(sck or cs_n);
      if (cs_n !== cs_q && cs_n === 1'h0) begin
        got = 32'h0;
        idx = int'(nbits) - 1;
        if (!cpha) begin
          miso = reply[idx];
          idx--;
        end
      end else if (cs_n !== cs_q) begin
        pkts++;
        miso = ~miso;
      end else if (!cs_n && ((sck != cpol) ^ cpha)) begin
        got = {got[30:0], mosi};
      end else if (!cs_n && idx >= 0) begin
        miso = reply[idx];
        idx--;
      end else begin
        miso = ~miso;
      end
      cs_q = cs_n;
    end
  end
endmodule : spc_target_model
